// File: rtl/comparator_defs.vh
// register offsets, field positions and reset values of the comparator block
`ifndef COMPARATOR_DEFS_VH
`define COMPARATOR_DEFS_VH

// byte offsets on the register bus
`define OFS_CTRL          4'h0
`define OFS_INT_STATUS    4'h4
`define OFS_INT_MASK      4'h8

// control word field positions
`define BIT_IDLE_STOP     15
`define BIT_UNUSED14      14
`define BIT_B_CHANGE      13
`define BIT_A_CHANGE      12
`define BIT_B_ON          11
`define BIT_A_ON          10
`define BIT_B_PAD         9
`define BIT_A_PAD         8
`define BIT_B_RESULT      7
`define BIT_A_RESULT      6
`define BIT_B_INVERT      5
`define BIT_A_INVERT      4
`define BIT_B_MINUS_SEL   3
`define BIT_B_PLUS_SEL    2
`define BIT_A_MINUS_SEL   1
`define BIT_A_PLUS_SEL    0

// interrupt status and mask field positions
`define BIT_INT_A         0
`define BIT_INT_B         1

// reset values
`define RST_CTRL          16'h0000
`define RST_INT_STATUS    2'h0
`define RST_INT_MASK      2'h0

`endif

// File: rtl/cmp_channel.v
// one comparator channel: input synchroniser, polarity, gating and change detect
`timescale 1ns/1ps

module cmp_channel (
  // clock, reset, clock enable
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  // configuration
  input  wire on,
  input  wire invert,
  // raw decision from the analog core
  input  wire raw,
  // digital result and change pulse
  output wire result,
  output wire change
);

  reg sync1_q;
  reg sync2_q;
  reg result_q;
  reg [2:0] on_hist_q;
  reg change_q;
  wire result_d;

  // disabled channel reads zero
  assign result_d = on & (sync2_q ^ invert);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      result_q  <= 1'b0;
      on_hist_q <= 3'h0;
      change_q  <= 1'b0;
    end else if (ce) begin
      // first stage feeds only the second
      sync1_q  <= raw;
      sync2_q  <= sync1_q;
      result_q  <= result_d;
      on_hist_q <= {on_hist_q[1:0], on};
      // a freshly powered core fills the sync pipe with junk, so events wait
      // until every stage holds a sample taken while switched on
      change_q  <= on & (&on_hist_q) & (result_d != result_q);
    end
  end

  assign result = result_q;
  assign change = change_q;

endmodule // cmp_channel

// File: rtl/dual_comparator_control.v
// control, status and interrupt logic for two analog comparators
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "comparator_defs.vh"

module dual_comparator_control #(
  parameter ADDR_W = 8
) (
  // clock, reset, clock enable
  input  wire              clk,
  input  wire              rst_n,
  input  wire              ce,
  // wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [ADDR_W-1:0] wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output wire [31:0]       wb_dat_o,
  output wire              wb_ack_o,
  // device power state
  input  wire              idle_mode,
  // comparator a analog core
  input  wire              cmp_a_raw,
  output wire              cmp_a_power,
  output wire              cmp_a_plus_sel,
  output wire              cmp_a_minus_sel,
  // comparator b analog core
  input  wire              cmp_b_raw,
  output wire              cmp_b_power,
  output wire              cmp_b_plus_sel,
  output wire              cmp_b_minus_sel,
  // output pads
  output wire              cmp_a_pad_out,
  output wire              cmp_a_pad_oe,
  output wire              cmp_b_pad_out,
  output wire              cmp_b_pad_oe,
  // interrupt
  output wire              irq
);

  //////////////////////////////////////////////////////////////////////////////
  // control word fields

  // power-on image of the control word
  localparam [15:0] CTRL_RST = `RST_CTRL;

  reg        idle_stop_ctl_q;
  reg        cmp_b_change_flag_q;
  reg        cmp_a_change_flag_q;
  reg        cmp_b_on_q;
  reg        cmp_a_on_q;
  reg        cmp_b_pad_drive_q;
  reg        cmp_a_pad_drive_q;
  reg        cmp_b_polarity_invert_q;
  reg        cmp_a_polarity_invert_q;
  reg        cmp_b_minus_select_q;
  reg        cmp_b_plus_select_q;
  reg        cmp_a_minus_select_q;
  reg        cmp_a_plus_select_q;

  // interrupt registers
  reg  [1:0] int_status_q;
  reg  [1:0] int_mask_q;
  reg        irq_q;

  // bus answer
  reg        ack_q;
  reg [31:0] dat_q;

  // pad drivers
  reg        pad_a_out_q;
  reg        pad_a_oe_q;
  reg        pad_b_out_q;
  reg        pad_b_oe_q;

  // channel results
  wire       cmp_a_result;
  wire       cmp_b_result;
  wire       cmp_a_change;
  wire       cmp_b_change;

  //////////////////////////////////////////////////////////////////////////////
  // the two comparator channels share one parameterless module

  cmp_channel u_cmp_a (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .on     (cmp_a_on_q),
    .invert (cmp_a_polarity_invert_q),
    .raw    (cmp_a_raw),
    .result (cmp_a_result),
    .change (cmp_a_change)
  );

  cmp_channel u_cmp_b (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .on     (cmp_b_on_q),
    .invert (cmp_b_polarity_invert_q),
    .raw    (cmp_b_raw),
    .result (cmp_b_result),
    .change (cmp_b_change)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire        req;
  wire        wr;
  wire        hit_ctrl;
  wire        hit_sts;
  wire        hit_mask;
  wire [15:0] ctrl_word;

  // one request per ack; ack falls in the cycle after it rose
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr  = req & wb_we_i;

  // full decode, aliases would hide software bugs
  assign hit_ctrl = (wb_adr_i == {{(ADDR_W-4){1'b0}}, `OFS_CTRL});
  assign hit_sts  = (wb_adr_i == {{(ADDR_W-4){1'b0}}, `OFS_INT_STATUS});
  assign hit_mask = (wb_adr_i == {{(ADDR_W-4){1'b0}}, `OFS_INT_MASK});

  // read image of the control word
  assign ctrl_word = {idle_stop_ctl_q,
                      1'b0,
                      cmp_b_change_flag_q,
                      cmp_a_change_flag_q,
                      cmp_b_on_q,
                      cmp_a_on_q,
                      cmp_b_pad_drive_q,
                      cmp_a_pad_drive_q,
                      cmp_b_result,
                      cmp_a_result,
                      cmp_b_polarity_invert_q,
                      cmp_a_polarity_invert_q,
                      cmp_b_minus_select_q,
                      cmp_b_plus_select_q,
                      cmp_a_minus_select_q,
                      cmp_a_plus_select_q};

  // byte lane strobes for the control word, status and mask registers
  // upper lanes carry nothing: every register is at most 16 bits wide
  wire wr_ctrl_lo;
  wire wr_ctrl_hi;
  wire wr_sts;
  wire wr_mask;

  assign wr_ctrl_lo = wr & hit_ctrl & wb_sel_i[0];
  assign wr_ctrl_hi = wr & hit_ctrl & wb_sel_i[1];
  assign wr_sts     = wr & hit_sts & wb_sel_i[0];
  assign wr_mask    = wr & hit_mask & wb_sel_i[0];

  //////////////////////////////////////////////////////////////////////////////
  // bus answer, one cycle after the request is seen

  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_d[15:0] = ctrl_word;
    end else if (hit_sts) begin
      rd_d[1:0] = int_status_q;
    end else if (hit_mask) begin
      rd_d[1:0] = int_mask_q;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce) begin
      // unmapped addresses still ack, reading zero
      ack_q <= req;
      if (req && !wb_we_i) begin
        dat_q <= rd_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control fields

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_b_polarity_invert_q <= CTRL_RST[`BIT_B_INVERT];
      cmp_a_polarity_invert_q <= CTRL_RST[`BIT_A_INVERT];
      cmp_b_minus_select_q    <= CTRL_RST[`BIT_B_MINUS_SEL];
      cmp_b_plus_select_q     <= CTRL_RST[`BIT_B_PLUS_SEL];
      cmp_a_minus_select_q    <= CTRL_RST[`BIT_A_MINUS_SEL];
      cmp_a_plus_select_q     <= CTRL_RST[`BIT_A_PLUS_SEL];
    end else if (ce && wr_ctrl_lo) begin
      // result bits 7:6 are read only
      cmp_b_polarity_invert_q <= wb_dat_i[`BIT_B_INVERT];
      cmp_a_polarity_invert_q <= wb_dat_i[`BIT_A_INVERT];
      cmp_b_minus_select_q    <= wb_dat_i[`BIT_B_MINUS_SEL];
      cmp_b_plus_select_q     <= wb_dat_i[`BIT_B_PLUS_SEL];
      cmp_a_minus_select_q    <= wb_dat_i[`BIT_A_MINUS_SEL];
      cmp_a_plus_select_q     <= wb_dat_i[`BIT_A_PLUS_SEL];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_stop_ctl_q   <= CTRL_RST[`BIT_IDLE_STOP];
      cmp_b_on_q        <= CTRL_RST[`BIT_B_ON];
      cmp_a_on_q        <= CTRL_RST[`BIT_A_ON];
      cmp_b_pad_drive_q <= CTRL_RST[`BIT_B_PAD];
      cmp_a_pad_drive_q <= CTRL_RST[`BIT_A_PAD];
    end else if (ce && wr_ctrl_hi) begin
      // bit 14 has no storage
      idle_stop_ctl_q   <= wb_dat_i[`BIT_IDLE_STOP];
      cmp_b_on_q        <= wb_dat_i[`BIT_B_ON];
      cmp_a_on_q        <= wb_dat_i[`BIT_A_ON];
      cmp_b_pad_drive_q <= wb_dat_i[`BIT_B_PAD];
      cmp_a_pad_drive_q <= wb_dat_i[`BIT_A_PAD];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // change flags: writing zero clears, writing one is ignored, a change wins

  wire clr_b_flag;
  wire clr_a_flag;

  assign clr_b_flag = wr_ctrl_hi & ~wb_dat_i[`BIT_B_CHANGE];
  assign clr_a_flag = wr_ctrl_hi & ~wb_dat_i[`BIT_A_CHANGE];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_b_change_flag_q <= CTRL_RST[`BIT_B_CHANGE];
      cmp_a_change_flag_q <= CTRL_RST[`BIT_A_CHANGE];
    end else if (ce) begin
      if (cmp_b_change) begin
        cmp_b_change_flag_q <= 1'b1;
      end else if (clr_b_flag) begin
        cmp_b_change_flag_q <= 1'b0;
      end
      if (cmp_a_change) begin
        cmp_a_change_flag_q <= 1'b1;
      end else if (clr_a_flag) begin
        cmp_a_change_flag_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output

  wire       int_quiet;
  wire [1:0] int_event;
  wire [1:0] int_clear;

  // comparators keep running in idle, only interrupts are held back
  assign int_quiet = idle_stop_ctl_q & idle_mode;
  assign int_event = {cmp_b_change, cmp_a_change} & {2{~int_quiet}};
  assign int_clear = {2{wr_sts}} & wb_dat_i[1:0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_status_q <= `RST_INT_STATUS;
    end else if (ce) begin
      // set wins over a simultaneous write-one-to-clear
      if (int_event[`BIT_INT_A]) begin
        int_status_q[`BIT_INT_A] <= 1'b1;
      end else if (int_clear[`BIT_INT_A]) begin
        int_status_q[`BIT_INT_A] <= 1'b0;
      end
      if (int_event[`BIT_INT_B]) begin
        int_status_q[`BIT_INT_B] <= 1'b1;
      end else if (int_clear[`BIT_INT_B]) begin
        int_status_q[`BIT_INT_B] <= 1'b0;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask_q <= `RST_INT_MASK;
      irq_q      <= 1'b0;
    end else if (ce) begin
      if (wr_mask) begin
        int_mask_q <= wb_dat_i[1:0];
      end
      // changes while idle-stopped never reach the status; status set earlier keeps irq low until idle ends or the idle stop bit is cleared
      irq_q <= |(int_status_q & int_mask_q) & ~int_quiet;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output pads

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_a_out_q <= 1'b0;
      pad_a_oe_q  <= 1'b0;
      pad_b_out_q <= 1'b0;
      pad_b_oe_q  <= 1'b0;
    end else if (ce) begin
      // a released pad shows low rather than a stale result
      pad_a_out_q <= cmp_a_result & cmp_a_pad_drive_q;
      pad_a_oe_q  <= cmp_a_pad_drive_q;
      pad_b_out_q <= cmp_b_result & cmp_b_pad_drive_q;
      pad_b_oe_q  <= cmp_b_pad_drive_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = dat_q;
  assign irq             = irq_q;
  assign cmp_a_power     = cmp_a_on_q;
  assign cmp_b_power     = cmp_b_on_q;
  assign cmp_a_plus_sel  = cmp_a_plus_select_q;
  assign cmp_a_minus_sel = cmp_a_minus_select_q;
  assign cmp_b_plus_sel  = cmp_b_plus_select_q;
  assign cmp_b_minus_sel = cmp_b_minus_select_q;
  assign cmp_a_pad_out   = pad_a_out_q;
  assign cmp_a_pad_oe    = pad_a_oe_q;
  assign cmp_b_pad_out   = pad_b_out_q;
  assign cmp_b_pad_oe    = pad_b_oe_q;

endmodule // dual_comparator_control

// File: test/analog_cmp_model.sv
// behavioural analog comparator core with its input routing
`timescale 1ns/1ps

module analog_cmp_model (
  // clock
  input  wire       clk,
  // power and routing from the block
  input  wire       power,
  input  wire       plus_sel,
  input  wire       minus_sel,
  // pin and reference levels
  input  wire [7:0] plus_pin,
  input  wire [7:0] minus_pin,
  input  wire [7:0] ref_level,
  // decision
  output logic      raw
);
  logic [7:0] vp;
  logic [7:0] vm;
  logic       junk_q = 1'b0;
  // a powered-down core gives no trustworthy level, so it toggles
  always @(posedge clk) junk_q <= ~junk_q;
  assign vp  = plus_sel ? plus_pin : ref_level;
  assign vm  = minus_sel ? plus_pin : minus_pin;
  assign raw = power ? (vp > vm) : junk_q;
endmodule // analog_cmp_model

// File: test/dual_comparator_control_monitor.sv
// port-level assertions for the comparator control block
`timescale 1ns/1ps

module dual_comparator_control_monitor #(
  parameter ADDR_W = 8
) (
  // clock and bus
  input wire              clk,
  input wire              rst_n,
  input wire              ce,
  input wire              wb_cyc_i,
  input wire              wb_stb_i,
  input wire              wb_we_i,
  input wire [ADDR_W-1:0] wb_adr_i,
  input wire [31:0]       wb_dat_o,
  input wire              wb_ack_o,
  // comparator controls
  input wire              cmp_a_power,
  input wire              cmp_a_plus_sel,
  input wire              cmp_a_minus_sel,
  input wire              cmp_a_pad_oe,
  input wire              cmp_a_pad_out,
  input wire              cmp_b_power,
  input wire              cmp_b_plus_sel,
  input wire              cmp_b_minus_sel,
  input wire              cmp_b_pad_oe,
  input wire              cmp_b_pad_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic req;
  logic ctl_wr;
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  assign ctl_wr = req && wb_we_i && (wb_adr_i == {ADDR_W{1'b0}});
  ////////////////////////////////////////////////////////////////////////
  ack_one_cycle_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack held too long");
  ack_answers_a: assert property (req |=> wb_ack_o)
    else $error("request not acked");
  ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  rdata_holds_a: assert property ($changed(wb_dat_o) |-> $past(req && !wb_we_i))
    else $error("read data moved without a read");
  a_cfg_write_a: assert property (
    $changed({cmp_a_power, cmp_a_plus_sel, cmp_a_minus_sel}) |-> $past(ctl_wr))
    else $error("comparator a setup moved without a write");
  b_cfg_write_a: assert property (
    $changed({cmp_b_power, cmp_b_plus_sel, cmp_b_minus_sel}) |-> $past(ctl_wr))
    else $error("comparator b setup moved without a write");
  a_pad_write_a: assert property (
    $changed(cmp_a_pad_oe) |-> $past(ctl_wr, 2))
    else $error("comparator a pad enable moved without a write");
  b_pad_write_a: assert property (
    $changed(cmp_b_pad_oe) |-> $past(ctl_wr, 2))
    else $error("comparator b pad enable moved without a write");
  a_off_quiet_a: assert property (!cmp_a_power [*5] |-> !cmp_a_pad_out)
    else $error("disabled comparator a drives a result");
  b_off_quiet_a: assert property (!cmp_b_power [*5] |-> !cmp_b_pad_out)
    else $error("disabled comparator b drives a result");
endmodule // dual_comparator_control_monitor

bind dual_comparator_control dual_comparator_control_monitor #(.ADDR_W(ADDR_W)) mon (
  .clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cmp_a_power(cmp_a_power), .cmp_a_plus_sel(cmp_a_plus_sel),
  .cmp_a_minus_sel(cmp_a_minus_sel), .cmp_a_pad_oe(cmp_a_pad_oe),
  .cmp_a_pad_out(cmp_a_pad_out), .cmp_b_power(cmp_b_power),
  .cmp_b_plus_sel(cmp_b_plus_sel), .cmp_b_minus_sel(cmp_b_minus_sel),
  .cmp_b_pad_oe(cmp_b_pad_oe), .cmp_b_pad_out(cmp_b_pad_out));

// File: test/tb_dual_comparator_control.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps

module tb_dual_comparator_control;
  logic        clk, rst_n, ce, cyc, stb, we, idle;
  logic [7:0]  adr, a_p, a_m, b_p, b_m, vref;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  wire  [31:0] dat_o;
  wire         ack, irq, a_raw, b_raw, a_pw, a_ps, a_ms, b_pw, b_ps, b_ms;
  wire         a_po, a_oe, b_po, b_oe;
  int          fail_count = 0;
  int          n_checks = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  dual_comparator_control DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .idle_mode(idle), .cmp_a_raw(a_raw),
    .cmp_a_power(a_pw), .cmp_a_plus_sel(a_ps), .cmp_a_minus_sel(a_ms),
    .cmp_b_raw(b_raw), .cmp_b_power(b_pw), .cmp_b_plus_sel(b_ps),
    .cmp_b_minus_sel(b_ms), .cmp_a_pad_out(a_po), .cmp_a_pad_oe(a_oe),
    .cmp_b_pad_out(b_po), .cmp_b_pad_oe(b_oe), .irq(irq));
  analog_cmp_model ma (.clk(clk), .power(a_pw), .plus_sel(a_ps), .minus_sel(a_ms),
    .plus_pin(a_p), .minus_pin(a_m), .ref_level(vref), .raw(a_raw));
  analog_cmp_model mb (.clk(clk), .power(b_pw), .plus_sel(b_ps), .minus_sel(b_ms),
    .plus_pin(b_p), .minus_pin(b_m), .ref_level(vref), .raw(b_raw));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one classic cycle, then one idle cycle so requests never touch
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    // no limit here: the watchdog ends a hung bus
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #20000;
    fail_count++;
    end_sim;
  end

  initial begin
    {cyc, stb, we, idle, rst_n} = 5'h00;
    {adr, wdat, sel, ce} = {8'h00, 32'h0, 4'hf, 1'b1};
    {a_p, a_m, b_p, b_m, vref} = {8'hc8, 8'h64, 8'h10, 8'h08, 8'h32};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h0);
    rdchk(8'hc0, 32'h0);
    bus(1'b1, 8'h00, 32'h4501);
    repeat (8) @(posedge clk);
    rdchk(8'h00, 32'h0541);
    check({a_pw, a_ps, a_ms, b_pw}, 4'hc);
    check({a_oe, a_po}, 2'h3);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h00, 32'h0400);
    repeat (8) @(posedge clk);
    rdchk(8'h00, 32'h1400);
    rdchk(8'h04, 32'h1);
    check(irq, 1'b1);
    bus(1'b1, 8'h00, 32'h1400);
    rdchk(8'h00, 32'h1400);
    bus(1'b1, 8'h00, 32'h0410);
    repeat (8) @(posedge clk);
    rdchk(8'h00, 32'h1450);
    bus(1'b1, 8'h04, 32'h1);
    rdchk(8'h04, 32'h0);
    check(irq, 1'b0);
    // stop-in-idle keeps the flag but drops the interrupt
    bus(1'b1, 8'h00, 32'h8410);
    idle <= 1'b1;
    a_m <= 8'h0a;
    repeat (8) @(posedge clk);
    rdchk(8'h00, 32'h9410);
    rdchk(8'h04, 32'h0);
    check(irq, 1'b0);
    bus(1'b1, 8'h00, 32'h0410);
    a_m <= 8'h64;
    repeat (8) @(posedge clk);
    rdchk(8'h04, 32'h1);
    check(irq, 1'b1);
    idle <= 1'b0;
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h00, 32'h0a0c);
    repeat (8) @(posedge clk);
    check({b_pw, b_ps, b_ms, b_oe, b_po, a_pw, a_oe}, 7'h78);
    rdchk(8'h00, 32'h0a0c);
    bus(1'b1, 8'h00, 32'h0a04);
    repeat (8) @(posedge clk);
    check(b_po, 1'b1);
    rdchk(8'h00, 32'h2a84);
    rdchk(8'h04, 32'h2);
    check(irq, 1'b0);
    bus(1'b1, 8'h00, 32'h0804);
    check(b_oe, 1'b0);
    bus(1'b1, 8'h00, 32'h0);
    repeat (8) @(posedge clk);
    rdchk(8'h00, 32'h0);
    // a low clock enable freezes result and pad until it returns
    bus(1'b1, 8'h00, 32'h0500);
    repeat (8) @(posedge clk);
    ce <= 1'b0;
    a_m <= 8'h0a;
    repeat (8) @(posedge clk);
    check({a_oe, a_po}, 2'h2);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    check({a_oe, a_po}, 2'h3);
    rdchk(8'h00, 32'h1540);
    end_sim;
  end
endmodule // tb_dual_comparator_control
